// [core/mhbt_port.sv]
// Multiplexed address/data host port: strobe decode, address latch and cycle control.
// How it works
// - Each strobe's active level comes from straps.
// - Strap optionally gates latch strobes with select.
// - High and low address latches accepted any order.
// - Read starts on strobe with select, ends deassert.
// - Write starts on strobe with select, ends deassert.
// - Strap selects separate strobes or direction plus enable.
`timescale 1ns/100ps
`include "mhbt_cfg.svh"
module mhbt_port
   import mhbt_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic addr_latch_low_strobe_i,
   input wire logic addr_latch_high_strobe_i,
   input wire logic select_i,
   input wire logic read_dir_i,
   input wire logic write_transfer_strobe_i,
   input wire logic [15:0] ad_i,
   output logic [15:0] ad_o,
   output logic ad_oe_o,
   input wire logic latch_strobe_level_strap_i,
   input wire logic select_level_strap_i,
   input wire logic read_dir_level_strap_i,
   input wire logic write_strobe_level_strap_i,
   input wire logic latch_gated_by_select_strap_i,
   input wire logic strobe_style_strap_i,
   output logic straps_ready_o,
   output logic req_valid_o,
   output mhbt_req_s req_o,
   input wire logic [15:0] rdata_i,
   input wire logic rdata_valid_i,
   output logic busy_o
);
   logic [`MHBT_SYNC_W-1:0] sync_vec;
   logic s_lo;
   logic s_hi;
   logic s_cs;
   logic s_rd;
   logic s_wr;
   logic [15:0] s_ad;
   mhbt_strap_s s_strap;
   mhbt_strap_s strap_reg;
   logic strap_valid_reg;
   logic cs_act;
   logic lo_act;
   logic hi_act;
   logic rd_go;
   logic wr_go;
   logic rd_hold;
   logic wr_hold;
   logic lo_prev_reg;
   logic hi_prev_reg;
   logic lo_fall;
   logic hi_fall;
   logic [15:0] ad_prev_reg;
   logic [15:0] addr_reg;
   logic [15:0] wdata_reg;
   mhbt_state_e state_reg;

   // Pin level compared to its strap level gives the active state.
   function automatic logic f_active(input logic pin, input logic level);
      f_active = (pin == level);
   endfunction : f_active

   // All host pins, straps included, are asynchronous to the core clock.
   mhbt_sync #(.W(`MHBT_SYNC_W)) u_sync (
      .core_clk_i(core_clk_i),
      .async_i({latch_strobe_level_strap_i, select_level_strap_i,
                read_dir_level_strap_i, write_strobe_level_strap_i,
                latch_gated_by_select_strap_i, strobe_style_strap_i, ad_i,
                write_transfer_strobe_i, read_dir_i, select_i,
                addr_latch_high_strobe_i, addr_latch_low_strobe_i}),
      .sync_o(sync_vec)
   );

   assign s_lo = sync_vec[0];
   assign s_hi = sync_vec[1];
   assign s_cs = sync_vec[2];
   assign s_rd = sync_vec[3];
   assign s_wr = sync_vec[4];
   assign s_ad = sync_vec[20:5];
   assign s_strap = mhbt_strap_s'(sync_vec[26:21]);

   // Straps are caught once after reset release, then frozen until the next reset.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         strap_reg <= '0;
         strap_valid_reg <= 1'b0;
      end else if (!strap_valid_reg) begin
         strap_reg <= s_strap;
         strap_valid_reg <= 1'b1;
      end
   end

   // Strobe decode; select, latch strobes and cycle starts are inactive until the straps are known.
   always_comb begin
      cs_act = strap_valid_reg && f_active(s_cs, strap_reg.select_level);
      lo_act = strap_valid_reg && f_active(s_lo, strap_reg.latch_level)
               && (!strap_reg.latch_gated || cs_act);
      hi_act = strap_valid_reg && f_active(s_hi, strap_reg.latch_level)
               && (!strap_reg.latch_gated || cs_act);
      if (strap_reg.dir_enable_style) begin
         // Direction plus enable: the write pin carries the enable strobe.
         rd_hold = f_active(s_wr, strap_reg.write_level);
         wr_hold = rd_hold;
         rd_go = rd_hold && cs_act && f_active(s_rd, strap_reg.read_dir_level);
         wr_go = wr_hold && cs_act && !f_active(s_rd, strap_reg.read_dir_level);
      end else begin
         rd_hold = f_active(s_rd, strap_reg.read_dir_level);
         wr_hold = f_active(s_wr, strap_reg.write_level);
         rd_go = rd_hold && cs_act;
         wr_go = wr_hold && cs_act && !rd_hold;
      end
   end

   assign lo_fall = lo_prev_reg && !lo_act;
   assign hi_fall = hi_prev_reg && !hi_act;

   // Previous strobe and bus samples; the bus seen with the strobe still active is kept.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         lo_prev_reg <= 1'b0;
         hi_prev_reg <= 1'b0;
         ad_prev_reg <= `MHBT_DATA_RST;
      end else begin
         lo_prev_reg <= lo_act;
         hi_prev_reg <= hi_act;
         ad_prev_reg <= s_ad;
      end
   end

   // Address latch. Both releasing together is single phase; otherwise each
   // strobe loads its byte from the low lane, so either order works.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         addr_reg <= `MHBT_ADDR_RST;
      end else if (lo_fall && hi_fall) begin
         addr_reg <= ad_prev_reg;
      end else if (lo_fall) begin
         addr_reg[`MHBT_LOW_LSB +: 8] <= ad_prev_reg[7:0];
      end else if (hi_fall) begin
         addr_reg[`MHBT_HIGH_LSB +: 8] <= ad_prev_reg[7:0];
      end
   end

   // Cycle state machine. A strobe shorter than one core clock may be
   // missed entirely; the pin timing assumes a faster sampling clock.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         state_reg <= MHBT_IDLE;
      end else begin
         case (state_reg)
            MHBT_IDLE: begin
               if (rd_go) begin
                  state_reg <= MHBT_READ;
               end else if (wr_go) begin
                  state_reg <= MHBT_WRITE;
               end
            end
            MHBT_READ: begin
               if (!rd_hold) begin
                  state_reg <= MHBT_IDLE;
               end
            end
            MHBT_WRITE: begin
               if (!wr_hold) begin
                  state_reg <= MHBT_IDLE;
               end
            end
            default: begin
               state_reg <= MHBT_IDLE;
            end
         endcase
      end
   end

   // Write data follows the bus while the strobe is active, so the last
   // sample before the trailing edge is what reaches the core.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         wdata_reg <= `MHBT_DATA_RST;
      end else if ((state_reg == MHBT_WRITE) && wr_hold) begin
         wdata_reg <= s_ad;
      end
   end

   // Core request: reads go out at cycle start, writes at cycle end.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         req_valid_o <= 1'b0;
         req_o <= '0;
      end else begin
         req_valid_o <= 1'b0;
         if ((state_reg == MHBT_IDLE) && rd_go) begin
            req_valid_o <= 1'b1;
            req_o <= '{write: 1'b0, addr: addr_reg, wdata: `MHBT_DATA_RST};
         end else if ((state_reg == MHBT_WRITE) && !wr_hold) begin
            req_valid_o <= 1'b1;
            req_o <= '{write: 1'b1, addr: addr_reg, wdata: wdata_reg};
         end
      end
   end

   // Read data register drives the bus only during a read cycle.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ad_o <= `MHBT_DATA_RST;
      end else if (rdata_valid_i) begin
         ad_o <= rdata_i;
      end
   end

   assign ad_oe_o = (state_reg == MHBT_READ);
   assign busy_o = (state_reg != MHBT_IDLE);
   assign straps_ready_o = strap_valid_reg;

   property p_read_req;
      @(posedge core_clk_i) disable iff (srst_i)
      (state_reg == MHBT_IDLE) && rd_go |=> req_valid_o && !req_o.write && ad_oe_o;
   endproperty
   a_read_req: assert property (p_read_req) else $error("read start gave no read request");
   property p_read_end;
      @(posedge core_clk_i) disable iff (srst_i)
      (state_reg == MHBT_READ) && !rd_hold |=> !ad_oe_o && !busy_o;
   endproperty
   a_read_end: assert property (p_read_end) else $error("read did not end on deassert");
   property p_write_req;
      @(posedge core_clk_i) disable iff (srst_i)
      (state_reg == MHBT_WRITE) && !wr_hold |=> req_valid_o && req_o.write
         && (req_o.wdata == $past(wdata_reg)) && (req_o.addr == $past(addr_reg));
   endproperty
   a_write_req: assert property (p_write_req) else $error("write end gave wrong request");
   property p_write_no_early;
      @(posedge core_clk_i) disable iff (srst_i)
      (state_reg == MHBT_WRITE) && wr_hold |=> !(req_valid_o && req_o.write);
   endproperty
   a_write_no_early: assert property (p_write_no_early) else $error("write issued early");
   property p_low_latch;
      @(posedge core_clk_i) disable iff (srst_i)
      lo_fall && !hi_fall |=> (addr_reg[7:0] == $past(ad_prev_reg[7:0]))
         && (addr_reg[15:8] == $past(addr_reg[15:8]));
   endproperty
   a_low_latch: assert property (p_low_latch) else $error("low address byte wrong");
   property p_high_latch;
      @(posedge core_clk_i) disable iff (srst_i)
      hi_fall && !lo_fall |=> (addr_reg[15:8] == $past(ad_prev_reg[7:0]))
         && (addr_reg[7:0] == $past(addr_reg[7:0]));
   endproperty
   a_high_latch: assert property (p_high_latch) else $error("high address byte wrong");

   property p_single_latch;
      @(posedge core_clk_i) disable iff (srst_i)
      lo_fall && hi_fall |=> addr_reg == $past(ad_prev_reg);
   endproperty
   a_single_latch: assert property (p_single_latch) else $error("single phase address wrong");

   property p_strap_frozen;
      @(posedge core_clk_i) disable iff (srst_i)
      strap_valid_reg |=> $stable(strap_reg) && straps_ready_o;
   endproperty
   a_strap_frozen: assert property (p_strap_frozen) else $error("straps changed after capture");

   property p_gate;
      @(posedge core_clk_i) disable iff (srst_i)
      strap_reg.latch_gated && !cs_act |=> !lo_prev_reg && !hi_prev_reg;
   endproperty
   a_gate: assert property (p_gate) else $error("ungated latch changed address");

   property p_style;
      @(posedge core_clk_i) disable iff (srst_i)
      (state_reg == MHBT_IDLE) && strap_reg.dir_enable_style
         && !f_active(s_wr, strap_reg.write_level) |=> !busy_o;
   endproperty
   a_style: assert property (p_style) else $error("cycle began without enable");

   c_read: cover property (@(posedge core_clk_i) disable iff (srst_i)
      (state_reg == MHBT_READ) [*2] ##1 (state_reg == MHBT_IDLE));
   c_write: cover property (@(posedge core_clk_i) disable iff (srst_i)
      req_valid_o && req_o.write);
   c_dual: cover property (@(posedge core_clk_i) disable iff (srst_i)
      hi_fall && !lo_fall ##[1:20] lo_fall && !hi_fall);
   c_enable_read: cover property (@(posedge core_clk_i) disable iff (srst_i)
      strap_reg.dir_enable_style && req_valid_o && !req_o.write);
endmodule : mhbt_port

// [core/mhbt_cfg.svh]
// Constant offsets, reset values and timing counts for the multiplexed host port.
`ifndef MHBT_CFG_SVH
`define MHBT_CFG_SVH
`define MHBT_CLK_PERIOD_NS 25
`define MHBT_T_STROBE_MIN_NS 32
`define MHBT_T_STROBE_MIN_CYC ((`MHBT_T_STROBE_MIN_NS + `MHBT_CLK_PERIOD_NS - 1) / `MHBT_CLK_PERIOD_NS)
`define MHBT_ADDR_RST 16'h0000
`define MHBT_DATA_RST 16'h0000
`define MHBT_LOW_LSB 0
`define MHBT_HIGH_LSB 8
`define MHBT_SYNC_W 27
`endif

// [core/mhbt_pkg.sv]
// Types shared by the multiplexed host port files.
package mhbt_pkg;
   typedef struct packed {
      logic latch_level;
      logic select_level;
      logic read_dir_level;
      logic write_level;
      logic latch_gated;
      logic dir_enable_style;
   } mhbt_strap_s;

   typedef struct packed {
      logic write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mhbt_req_s;

   typedef enum logic [1:0] {
      MHBT_IDLE,
      MHBT_READ,
      MHBT_WRITE
   } mhbt_state_e;
endpackage : mhbt_pkg

// [core/mhbt_sync.sv]
// Two-flop synchroniser bank for the asynchronous host pins.
`timescale 1ns/100ps
module mhbt_sync #(
   parameter int W = 27
) (
   input wire logic core_clk_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_reg;

   // Each bit gets its own pair; the first flop feeds only the second.
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_bit
         always_ff @(posedge core_clk_i) begin
            meta_reg[gi] <= async_i[gi];
            sync_o[gi] <= meta_reg[gi];
         end
      end
   endgenerate
endmodule : mhbt_sync

// [verif/mhbt_host_model.sv]
// Behavioural host processor that drives the multiplexed port pins.
`timescale 1ns/100ps
module mhbt_host_model
   import mhbt_pkg::*;
(
   input wire logic core_clk_i,
   input wire mhbt_strap_s straps_i,
   input wire logic [15:0] bus_i,
   output logic low_o,
   output logic high_o,
   output logic sel_o,
   output logic rd_dir_o,
   output logic wr_en_o,
   output logic [15:0] ad_o
);
   // Pin level for a logical state; a strap of one means active high.
   function automatic logic lv(input logic act, input logic strap);
      return act ~^ strap;
   endfunction : lv

   // Parks every strobe at its inactive level while the device sits in reset.
   task automatic idle();
      low_o <= lv(1'b0, straps_i.latch_level);
      high_o <= lv(1'b0, straps_i.latch_level);
      sel_o <= lv(1'b0, straps_i.select_level);
      rd_dir_o <= lv(1'b0, straps_i.read_dir_level);
      wr_en_o <= lv(1'b0, straps_i.write_level);
      ad_o <= 16'h0000;
   endtask : idle

   // One address phase; select rides along with the latch strobes when asked.
   task automatic latch(input logic [1:0] which, input logic [15:0] v, input logic sel_on);
      @(posedge core_clk_i);
      ad_o <= v;
      sel_o <= lv(sel_on, straps_i.select_level);
      low_o <= lv(which[0], straps_i.latch_level);
      high_o <= lv(which[1], straps_i.latch_level);
      // Three cycles keep the pulse clear of the two-flop sampling loss.
      repeat (3) @(posedge core_clk_i);
      low_o <= lv(1'b0, straps_i.latch_level);
      high_o <= lv(1'b0, straps_i.latch_level);
      sel_o <= lv(1'b0, straps_i.select_level);
      repeat (3) @(posedge core_clk_i);
      ad_o <= ~v;
   endtask : latch

   // One read or write; in direction plus enable style the direction leads the enable strobe by a cycle.
   task automatic cycle(input logic wr, input logic [15:0] d, input logic sel_on,
                        output logic [15:0] rd);
      @(posedge core_clk_i);
      if (straps_i.dir_enable_style) rd_dir_o <= lv(!wr, straps_i.read_dir_level);
      @(posedge core_clk_i);
      sel_o <= lv(sel_on, straps_i.select_level);
      rd_dir_o <= lv(!wr, straps_i.read_dir_level);
      wr_en_o <= lv(straps_i.dir_enable_style | wr, straps_i.write_level);
      ad_o <= wr ? d : ~ad_o;
      repeat (8) @(posedge core_clk_i);
      rd = bus_i;
      sel_o <= lv(1'b0, straps_i.select_level);
      wr_en_o <= lv(1'b0, straps_i.write_level);
      if (!straps_i.dir_enable_style) rd_dir_o <= lv(1'b0, straps_i.read_dir_level);
      // The recovery gap covers every follow-on case, so ordering never matters.
      repeat (4) @(posedge core_clk_i);
      rd_dir_o <= lv(1'b0, straps_i.read_dir_level);
      ad_o <= ~ad_o;
   endtask : cycle
endmodule : mhbt_host_model

// [verif/muxed_host_bus_cycle_timing_test.sv]
// Self-checking bench for the multiplexed host port with a host model and a request model.
`timescale 1ns/100ps
`include "mhbt_cfg.svh"
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin fail_count++; $display("[ERR] %s expected %h seen %h", n, e, s); end end
module muxed_host_bus_cycle_timing_test
   import mhbt_pkg::*;
   ;
   logic core_clk_i, srst_i, low, high, sel, rd_dir, wr_en;
   logic ad_oe, straps_ready, req_valid, busy, rdata_valid_i, pend;
   logic [15:0] host_ad, ad_o, bus, rdata_i, rv, exp_addr;
   logic [5:0] cfg;
   mhbt_strap_s straps;
   mhbt_req_s req, e;
   mhbt_req_s exp_q[$];
   logic [15:0] rd_q[$];
   int fail_count, compares;

   // The device wins the shared bus whenever it drives it.
   assign bus = ad_oe ? ad_o : host_ad;

   mhbt_port dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .addr_latch_low_strobe_i(low),
      .addr_latch_high_strobe_i(high), .select_i(sel), .read_dir_i(rd_dir),
      .write_transfer_strobe_i(wr_en), .ad_i(bus), .ad_o(ad_o), .ad_oe_o(ad_oe),
      .latch_strobe_level_strap_i(straps.latch_level),
      .select_level_strap_i(straps.select_level),
      .read_dir_level_strap_i(straps.read_dir_level),
      .write_strobe_level_strap_i(straps.write_level),
      .latch_gated_by_select_strap_i(straps.latch_gated),
      .strobe_style_strap_i(straps.dir_enable_style), .straps_ready_o(straps_ready),
      .req_valid_o(req_valid), .req_o(req), .rdata_i(rdata_i),
      .rdata_valid_i(rdata_valid_i), .busy_o(busy));

   mhbt_host_model host (.core_clk_i(core_clk_i), .straps_i(straps), .bus_i(bus),
      .low_o(low), .high_o(high), .sel_o(sel), .rd_dir_o(rd_dir), .wr_en_o(wr_en),
      .ad_o(host_ad));

   // Clock generation.
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out

   // New straps only take effect through a reset, so each configuration resets.
   task automatic do_reset(input mhbt_strap_s s);
      @(posedge core_clk_i);
      straps <= s;
      srst_i <= 1'b1;
      @(posedge core_clk_i);
      host.idle();
      repeat (9) @(posedge core_clk_i);
      srst_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      #1 `CHK("straps_ready", 1'b1, straps_ready)
      exp_addr = `MHBT_ADDR_RST;
   endtask : do_reset

   // Address phase plus the model's view of which address bytes it loads.
   task automatic latch(input logic [1:0] w, input logic s);
      logic [15:0] v;
      v = 16'($urandom);
      host.latch(w, v, s);
      if (!straps.latch_gated || s) begin
         if (w == 2'b11) exp_addr = v;
         else if (w[0]) exp_addr[7:0] = v[7:0];
         else exp_addr[15:8] = v[7:0];
      end
   endtask : latch

   // One host transfer; without select no request may appear.
   task automatic xfer(input logic wr, input logic s);
      logic [15:0] d, got;
      d = 16'($urandom);
      if (s) exp_q.push_back('{write: wr, addr: exp_addr, wdata: d});
      host.cycle(wr, d, s, got);
      #1 if (!wr && s) `CHK("read_data", rd_q.pop_front(), got)
      `CHK("bus_released", 1'b0, ad_oe)
      `CHK("idle", 1'b0, busy)
   endtask : xfer

   // Request monitor and core responder; reads get random data a cycle later.
   always @(negedge core_clk_i) begin
      if (req_valid === 1'b1) begin
         if (exp_q.size() == 0) `CHK("spare_request", 1'b0, 1'b1)
         else begin
            e = exp_q.pop_front();
            `CHK("req_write", e.write, req.write)
            `CHK("req_addr", e.addr, req.addr)
            if (e.write) `CHK("req_wdata", e.wdata, req.wdata)
            else begin
               rv = 16'($urandom);
               rd_q.push_back(rv);
               pend = 1'b1;
            end
         end
      end
   end

   // Drives the read answer on the rising edge.
   always @(posedge core_clk_i) begin
      rdata_valid_i <= pend;
      rdata_i <= rv;
      pend = 1'b0;
   end

   // Watchdog sized well above the expected run of about 1600 cycles.
   initial begin
      #(40000 * 25);
      fail_count++;
      close_out();
   end

   // Main sequence over strap settings, both latch orders and refused cycles.
   initial begin
      straps = '0;
      srst_i = 1'b1;
      rdata_valid_i = 1'b0;
      rdata_i = 16'h0000;
      rv = 16'h0000;
      pend = 1'b0;
      host.idle();
      void'($urandom(32'h641A));
      for (int i = 0; i < 8; i++) begin
         cfg = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
         do_reset(mhbt_strap_s'(cfg));
         latch(2'b10, 1'b1);
         latch(2'b01, 1'b1);
         xfer(1'b1, 1'b1);
         xfer(1'b0, 1'b1);
         latch(2'b01, 1'b1);
         latch(2'b10, 1'b1);
         xfer(1'b0, 1'b1);
         xfer(1'b0, 1'b1);
         xfer(1'b1, 1'b1);
         latch(2'b11, 1'b1);
         xfer(1'b1, 1'b1);
         xfer(1'b1, 1'b1);
         xfer(1'b0, 1'b0);
         xfer(1'b1, 1'b0);
         latch(2'b11, 1'b0);
         xfer(1'b0, 1'b1);
         repeat (4) @(posedge core_clk_i);
         `CHK("pending", 0, exp_q.size())
         $display("test strap set %0d value %h done", i, cfg);
      end
      close_out();
   end
endmodule : muxed_host_bus_cycle_timing_test
